// ===== core/eip_params.svh
`ifndef EIP_PARAMS_SVH
`define EIP_PARAMS_SVH
`define EIP_PRIO_ADDR 8'hF6
`define EIP_ENABLE_ADDR 8'hE6
`define EIP_PRIO_RESET 8'h00
`define EIP_ENABLE_RESET 8'h00
`define EIP_BIT_TIMER3 3'd7
`define EIP_BIT_CMP1 3'd6
`define EIP_BIT_CMP0 3'd5
`define EIP_BIT_PCA 3'd4
`define EIP_BIT_CONV 3'd3
`define EIP_BIT_WIN 3'd2
`define EIP_BIT_USB 3'd1
`define EIP_BIT_TWI 3'd0
`endif

// ===== core/eip_pkg.sv
package eip_pkg;
   typedef logic [7:0] eip_byte_t;
   typedef enum logic [2:0] {
      EIP_IDLE = 3'b001,
      EIP_LOW = 3'b010,
      EIP_HIGH = 3'b100
   } eip_level_e;
endpackage : eip_pkg

// ===== core/eip_arbiter.sv
`timescale 1ns/1ps
// Picks the lowest-index pending source within each level
module eip_arbiter (
   input wire logic [7:0] req_i,
   input wire logic [7:0] enable_i,
   input wire logic [7:0] prio_i,
   output logic hi_any_o,
   output logic lo_any_o,
   output logic [2:0] hi_idx_o,
   output logic [2:0] lo_idx_o
);
   function automatic logic [2:0] first_set(input logic [7:0] v);
      logic [2:0] r;
      r = 3'h0;
      for (int i = 7; i >= 0; i--) begin
         if (v[i]) begin
            r = 3'(i);
         end
      end
      return r;
   endfunction : first_set

   wire [7:0] live = req_i & enable_i;
   wire [7:0] hi_set = live & prio_i;
   wire [7:0] lo_set = live & ~prio_i;
   assign hi_any_o = |hi_set;
   assign lo_any_o = |lo_set;
   assign hi_idx_o = first_set(hi_set);
   assign lo_idx_o = first_set(lo_set);
endmodule : eip_arbiter

// ===== core/eip_top.sv
`timescale 1ns/1ps
`include "eip_params.svh"
module eip_top (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic clk_en_i,
   input wire logic [7:0] sfr_addr_i,
   input wire logic sfr_wr_i,
   input wire logic [7:0] sfr_wdata_i,
   output eip_pkg::eip_byte_t sfr_rdata_o,
   input wire logic [7:0] src_req_i,
   input wire logic svc_done_i,
   output logic irq_valid_o,
   output logic [2:0] irq_idx_o,
   output logic irq_high_o,
   output eip_pkg::eip_byte_t src_high_o,
   output eip_pkg::eip_level_e level_o
);
   import eip_pkg::*;

   eip_byte_t prio_q;
   eip_byte_t enable_q;
   eip_byte_t rdata_q;
   eip_level_e level_q;
   eip_level_e level_d;
   logic valid_q;
   logic [2:0] idx_q;
   logic high_q;
   logic hi_any;
   logic lo_any;
   logic [2:0] hi_idx;
   logic [2:0] lo_idx;

   function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] reg_addr);
      return addr == reg_addr;
   endfunction : addr_hit

   wire sel_prio = addr_hit(sfr_addr_i, `EIP_PRIO_ADDR);
   wire sel_enable = addr_hit(sfr_addr_i, `EIP_ENABLE_ADDR);
   wire wr_prio = sfr_wr_i && sel_prio;
   wire wr_enable = sfr_wr_i && sel_enable;
   wire [7:0] rdata_d = sel_prio ? prio_q : (sel_enable ? enable_q : 8'h00);

   // Per-source level: set bit is high, clear bit is low
   wire [7:0] src_high_d = {prio_q[`EIP_BIT_TIMER3],
                            prio_q[`EIP_BIT_CMP1],
                            prio_q[`EIP_BIT_CMP0],
                            prio_q[`EIP_BIT_PCA],
                            prio_q[`EIP_BIT_CONV],
                            prio_q[`EIP_BIT_WIN],
                            prio_q[`EIP_BIT_USB],
                            prio_q[`EIP_BIT_TWI]};

   eip_arbiter u_arb (
      .req_i(src_req_i),
      .enable_i(enable_q),
      .prio_i(prio_q),
      .hi_any_o(hi_any),
      .lo_any_o(lo_any),
      .hi_idx_o(hi_idx),
      .lo_idx_o(lo_idx)
   );

   // Grant: high preempts idle or low; low only from idle
   wire take_high = hi_any && (level_q != EIP_HIGH);
   wire take_low = lo_any && !hi_any && (level_q == EIP_IDLE);
   wire grant = take_high || take_low;

   always_comb begin
      level_d = level_q;
      case (level_q)
         EIP_IDLE: begin
            if (take_high) begin
               level_d = EIP_HIGH;
            end else if (take_low) begin
               level_d = EIP_LOW;
            end
         end
         EIP_LOW: begin
            if (take_high) begin
               level_d = EIP_HIGH;
            end else if (svc_done_i) begin
               level_d = EIP_IDLE;
            end
         end
         EIP_HIGH: begin
            if (svc_done_i) begin
               level_d = EIP_IDLE;
            end
         end
         default: level_d = EIP_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         prio_q <= `EIP_PRIO_RESET;
         enable_q <= `EIP_ENABLE_RESET;
      end else if (clk_en_i) begin
         if (wr_prio) begin
            prio_q <= sfr_wdata_i;
         end
         if (wr_enable) begin
            enable_q <= sfr_wdata_i;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         rdata_q <= 8'h00;
         src_high_o <= 8'h00;
      end else if (clk_en_i) begin
         rdata_q <= rdata_d;
         src_high_o <= src_high_d;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         level_q <= EIP_IDLE;
         valid_q <= 1'b0;
         idx_q <= 3'h0;
         high_q <= 1'b0;
      end else if (clk_en_i) begin
         level_q <= level_d;
         valid_q <= grant;
         if (grant) begin
            idx_q <= take_high ? hi_idx : lo_idx;
            high_q <= take_high;
         end
      end
   end

   assign sfr_rdata_o = rdata_q;
   assign irq_valid_o = valid_q;
   assign irq_idx_o = idx_q;
   assign irq_high_o = high_q;
   assign level_o = level_q;

   // Nested high service never granted
   no_high_nest_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (level_q == EIP_HIGH && clk_en_i && !svc_done_i) |=> (level_q == EIP_HIGH && !valid_q))
      else $error("high service was preempted");
   high_preempt_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (level_q == EIP_LOW && hi_any && clk_en_i) |=> (level_q == EIP_HIGH && valid_q && high_q))
      else $error("high request did not preempt low service");
   masked_src_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (grant && clk_en_i) |=> enable_q[idx_q] || $past(wr_enable))
      else $error("masked source granted");
   grant_level_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (grant && clk_en_i && !wr_prio) |=> (high_q == prio_q[idx_q]))
      else $error("granted level does not match priority bit");
   prio_write_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (wr_prio && clk_en_i) |=> (prio_q == $past(sfr_wdata_i))
      ##1 (!$past(clk_en_i) || src_high_o == $past(prio_q)))
      else $error("priority write not reflected");
   src_map_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (clk_en_i) |=> (src_high_o[`EIP_BIT_PCA] == $past(prio_q[`EIP_BIT_PCA])
                     && src_high_o[`EIP_BIT_TIMER3] == $past(prio_q[`EIP_BIT_TIMER3])))
      else $error("source level map wrong");
   conv_map_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (clk_en_i) |=> (src_high_o[`EIP_BIT_CONV] == $past(prio_q[`EIP_BIT_CONV])
                     && src_high_o[`EIP_BIT_WIN] == $past(prio_q[`EIP_BIT_WIN])))
      else $error("converter level map wrong");
   serial_map_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (clk_en_i) |=> (src_high_o[`EIP_BIT_USB] == $past(prio_q[`EIP_BIT_USB])
                     && src_high_o[`EIP_BIT_TWI] == $past(prio_q[`EIP_BIT_TWI])))
      else $error("serial level map wrong");

   // Register write, hold and readback
   prio_hold_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      !(wr_prio && clk_en_i) |=> $stable(prio_q))
      else $error("priority register changed without a write");
   enable_write_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (wr_enable && clk_en_i) |=> (enable_q == $past(sfr_wdata_i)))
      else $error("enable write not taken");
   enable_hold_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      !(wr_enable && clk_en_i) |=> $stable(enable_q))
      else $error("enable register changed without a write");
   prio_read_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (sel_prio && clk_en_i) |=> (sfr_rdata_o == $past(prio_q)))
      else $error("priority readback wrong");
   enable_read_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (sel_enable && clk_en_i) |=> (sfr_rdata_o == $past(enable_q)))
      else $error("enable readback wrong");

   // Service level moves
   idle_low_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (level_q == EIP_IDLE && lo_any && !hi_any && clk_en_i)
      |=> (level_q == EIP_LOW && valid_q && !high_q))
      else $error("idle low request not granted");
   high_grant_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (level_q != EIP_HIGH && hi_any && clk_en_i)
      |=> (level_q == EIP_HIGH && valid_q && high_q))
      else $error("high request not granted");
   low_no_nest_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (level_q == EIP_LOW && !hi_any && !svc_done_i && clk_en_i)
      |=> (level_q == EIP_LOW && !valid_q))
      else $error("low service was preempted by low");
   high_return_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (level_q == EIP_HIGH && svc_done_i && clk_en_i)
      |=> (level_q == EIP_IDLE && !valid_q))
      else $error("high service did not return to idle");
   masked_none_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      (clk_en_i && (src_req_i & enable_q) == 8'h00) |=> !valid_q)
      else $error("grant without an enabled request");
   state_freeze_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      !clk_en_i |=> ($stable(level_q) && $stable(valid_q) && $stable(src_high_o)))
      else $error("state moved while clock enable low");
   src_level_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      valid_q |-> (high_q == src_high_o[idx_q]))
      else $error("grant level differs from source level");
   valid_level_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      valid_q |-> (level_q != EIP_IDLE))
      else $error("grant shown while idle");
endmodule : eip_top

// ===== tb/eip_top_bench.sv
`timescale 1ns/1ps
module eip_top_bench;
   import eip_pkg::*;
   logic ref_clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic clk_en_i = 1'b1;
   logic [7:0] sfr_addr_i = 8'h00;
   logic sfr_wr_i = 1'b0;
   logic [7:0] sfr_wdata_i = 8'h00;
   logic [7:0] src_req_i = 8'h00;
   logic svc_done_i = 1'b0;
   eip_byte_t sfr_rdata_o;
   eip_byte_t src_high_o;
   logic irq_valid_o;
   logic [2:0] irq_idx_o;
   logic irq_high_o;
   eip_level_e level_o;
   int err_count = 0;
   int tests_run = 0;
   logic [19:0] rows [8];
   always #5 ref_clk_i = ~ref_clk_i;
   eip_top dut (.ref_clk_i, .srst_i, .clk_en_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i,
      .sfr_rdata_o, .src_req_i, .svc_done_i, .irq_valid_o, .irq_idx_o, .irq_high_o,
      .src_high_o, .level_o);
   task chk(input logic [7:0] s, input logic [7:0] e, input string n);
      tests_run++;
      if (s !== e) begin
         $display("MISMATCH %s expected %h seen %h", n, e, s);
         err_count++;
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk_i);
      sfr_addr_i = a;
      sfr_wdata_i = d;
      sfr_wr_i = 1'b1;
      @(negedge ref_clk_i);
      sfr_wr_i = 1'b0;
   endtask : wr
   task rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge ref_clk_i);
      sfr_addr_i = a;
      @(negedge ref_clk_i);
      chk(sfr_rdata_o, e, "rdata");
   endtask : rd
   task grant(input logic [2:0] x, input logic h);
      int n;
      n = 0;
      do begin
         @(negedge ref_clk_i);
         n++;
      end while (irq_valid_o !== 1'b1 && n < 4);
      chk(irq_valid_o, 8'h01, "valid");
      chk(irq_idx_o, x, "idx");
      chk(irq_high_o, h, "high");
      chk(level_o, h ? 8'h04 : 8'h02, "level");
   endtask : grant
   task done_svc;
      src_req_i = 8'h00;
      svc_done_i = 1'b1;
      @(negedge ref_clk_i);
      svc_done_i = 1'b0;
   endtask : done_svc
   task test_done;
      $display("Counts: %0d checks, %0d mismatches", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : test_done
   initial begin
      #40000;
      err_count++;
      test_done();
   end
   initial begin
      rows = '{{8'h80, 8'h80, 3'd7, 1'b1}, {8'h40, 8'h40, 3'd6, 1'b1},
         {8'hDF, 8'h20, 3'd5, 1'b0}, {8'h10, 8'h10, 3'd4, 1'b1},
         {8'hF7, 8'h08, 3'd3, 1'b0}, {8'h04, 8'h04, 3'd2, 1'b1},
         {8'h02, 8'h02, 3'd1, 1'b1}, {8'hFE, 8'h01, 3'd0, 1'b0}};
      repeat (2) @(negedge ref_clk_i);
      srst_i = 1'b0;
      rd(8'hF6, 8'h00);
      rd(8'hE6, 8'h00);
      chk(level_o, 8'h01, "idle");
      clk_en_i = 1'b0;
      wr(8'hF6, 8'hFF);
      clk_en_i = 1'b1;
      wr(8'h00, 8'h5A);
      rd(8'h00, 8'h00);
      rd(8'hF6, 8'h00);
      $display("reset and access test done");
      for (int i = 0; i < 8; i++) begin
         wr(8'hF6, rows[i][19:12]);
         wr(8'hE6, 8'hFF);
         @(negedge ref_clk_i);
         chk(src_high_o, rows[i][19:12], "src_high");
         src_req_i = rows[i][11:4];
         grant(rows[i][3:1], rows[i][0]);
         done_svc();
      end
      $display("row test done");
      wr(8'hF6, 8'hC0);
      wr(8'hE6, 8'hFE);
      rd(8'hF6, 8'hC0);
      rd(8'hE6, 8'hFE);
      src_req_i = 8'h01;
      repeat (3) begin
         @(negedge ref_clk_i);
         chk(irq_valid_o, 8'h00, "masked");
      end
      wr(8'hE6, 8'hFF);
      grant(3'd0, 1'b0);
      src_req_i = 8'h41;
      grant(3'd6, 1'b1);
      src_req_i = 8'hC1;
      repeat (3) begin
         @(negedge ref_clk_i);
         chk(irq_valid_o, 8'h00, "nested");
      end
      done_svc();
      $display("mask and preempt test done");
      src_req_i = 8'h0C;
      grant(3'd2, 1'b0);
      src_req_i = 8'h0D;
      repeat (3) begin
         @(negedge ref_clk_i);
         chk(irq_valid_o, 8'h00, "low nest");
      end
      svc_done_i = 1'b1;
      @(negedge ref_clk_i);
      svc_done_i = 1'b0;
      grant(3'd0, 1'b0);
      done_svc();
      $display("low service test done");
      clk_en_i = 1'b0;
      src_req_i = 8'h80;
      repeat (3) begin
         @(negedge ref_clk_i);
         chk(irq_valid_o, 8'h00, "frozen");
      end
      chk(level_o, 8'h01, "frozen level");
      clk_en_i = 1'b1;
      grant(3'd7, 1'b1);
      done_svc();
      $display("clock enable test done");
      src_req_i = 8'h01;
      grant(3'd0, 1'b0);
      srst_i = 1'b1;
      repeat (2) @(negedge ref_clk_i);
      srst_i = 1'b0;
      chk(level_o, 8'h01, "reset level");
      chk(irq_valid_o, 8'h00, "reset valid");
      chk(irq_idx_o, 8'h00, "reset idx");
      chk(irq_high_o, 8'h00, "reset high");
      chk(src_high_o, 8'h00, "reset src_high");
      @(negedge ref_clk_i);
      chk(irq_valid_o, 8'h00, "reset masked");
      src_req_i = 8'h00;
      rd(8'hF6, 8'h00);
      rd(8'hE6, 8'h00);
      $display("mid-run reset test done");
      test_done();
   end
endmodule : eip_top_bench
